// file: inc/flash_rcr_map.svh
`ifndef FLASH_RCR_MAP_SVH
`define FLASH_RCR_MAP_SVH
// ----------------------------------------
// configuration register layout
// ----------------------------------------
`define RCR_RESET        16'hBFCF
`define RCR_RSV_MASK     16'h4030
`define RCR_FORCE_SET    16'h0080
`define RCR_LAT_MIN      3'h2
`define RCR_BL_4         3'h1
`define RCR_BL_8         3'h2
`define RCR_BL_16        3'h3
// ----------------------------------------
// commands and identifier space
// ----------------------------------------
`define CMD_CFG_SETUP    8'h60
`define CMD_CFG_CONFIRM  8'h03
`define CMD_READ_IDENT   8'h90
`define CMD_READ_ARRAY   8'hFF
`define IDENT_RCR_OFFSET 8'h05
`endif

// file: inc/flash_rcr_pkg.sv
`default_nettype none
package flash_rcr_pkg;
   typedef struct packed {
      logic       readModeSelect;
      logic       rsv14;
      logic [2:0] firstAccessLatency;
      logic       waitHigh;
      logic       dataHoldLen;
      logic       waitDelaySel;
      logic       burstOrder;
      logic       clkRising;
      logic [1:0] rsv5to4;
      logic       burstWrapCtl;
      logic [2:0] burstLength;
   } read_config_reg_t;

   typedef struct packed {
      read_config_reg_t cfg;
      logic             identMode;
   } link_cfg_t;

   typedef enum logic {SPACE_ARRAY, SPACE_IDENT} read_space_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_LATENCY, BUS_DATA} burst_state_t;
endpackage
`default_nettype wire

// file: hdl/flash_read_config_burst.sv
// Operation
// - bit 15 picks sync burst (0) or async page reads (1, default)
// - register changes only through the configure command sequence
// - identifier read at offset 0x05 returns the register
// - bits 13:11 latency code 2..7, default 7
// - first data after latency count from address-valid edge
// - bit 10 WAIT polarity, 1 active high default
// - WAIT changes only on valid edges during active cycles
// - sync reads deassert WAIT while data is valid
// - async reads and writes hold WAIT deasserted
// - WAIT released unless chip and output enable both low
// - end of word line WAIT only right on first access
// - bit 9 data hold two clocks (default) or one
// - bit 8 WAIT deasserts one data cycle early (default)
// - bit 3 clear wraps inside burst length, set no wrap
// - bits 2:0 burst length 4, 8, 16 or continuous
// - burst order bit only linear, always one
// - clock edge bit picks rising or falling valid edge
// - non-array sync reads repeat the same word
`timescale 1ns/1ns
`default_nettype none
`include "flash_rcr_map.svh"
module flash_read_config_burst #(
   parameter int AW = 16
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          linkClk,
   input  wire logic          ceN,
   input  wire logic          oeN,
   input  wire logic          weN,
   input  wire logic          addressValidN,
   input  wire logic [AW-1:0] addr,
   input  wire logic [15:0]   dqIn,
   input  wire logic [15:0]   arrayRdata,
   output logic      [15:0]   dqOut,
   output logic               dqOe,
   output logic               waitOut,
   output logic               waitOe,
   output logic      [AW-1:0] arrayRaddr
);
   // ----------------------------------------
   // pin synchronisers, system side
   // ----------------------------------------
   logic [2:0]    ctlS1_ff;
   logic [2:0]    ctlS2_ff;
   logic          weDly_ff;
   logic [AW-1:0] addrS1_ff;
   logic [AW-1:0] addrS2_ff;
   logic [15:0]   dqS1_ff;
   logic [15:0]   dqS2_ff;
   logic          wrEnd;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctlS1_ff  <= 3'h7;
         ctlS2_ff  <= 3'h7;
         weDly_ff  <= 1'b1;
         addrS1_ff <= '0;
         addrS2_ff <= '0;
         dqS1_ff   <= 16'h0000;
         dqS2_ff   <= 16'h0000;
      end else begin
         ctlS1_ff  <= {ceN, oeN, weN};
         ctlS2_ff  <= ctlS1_ff;
         weDly_ff  <= ctlS2_ff[0];
         addrS1_ff <= addr;
         addrS2_ff <= addrS1_ff;
         dqS1_ff   <= dqIn;
         dqS2_ff   <= dqS1_ff;
      end
   end

   // write data is taken at the rising edge of the write strobe
   assign wrEnd = ctlS2_ff[0] && !weDly_ff && !ctlS2_ff[2];

   // ----------------------------------------
   // command decode and configuration
   // ----------------------------------------
   flash_rcr_pkg::read_config_reg_t cfg_ff;
   flash_rcr_pkg::read_config_reg_t nxt_cfg;
   flash_rcr_pkg::read_space_t      space_ff;
   flash_rcr_pkg::read_space_t      nxt_space;
   logic                            pend_ff;
   logic                            nxt_pend;
   logic                            tog_ff;
   logic                            nxt_tog;
   logic                            cfgWrite;

   always_comb begin
      nxt_cfg   = cfg_ff;
      nxt_space = space_ff;
      nxt_pend  = 1'b0;
      cfgWrite  = 1'b0;
      if (wrEnd) begin
         if (pend_ff && dqS2_ff[7:0] == `CMD_CFG_CONFIRM) begin
            // new value rides on the address lines
            cfgWrite = 1'b1;
            nxt_cfg  = (addrS2_ff[15:0] & ~`RCR_RSV_MASK) | `RCR_FORCE_SET;
         end else if (dqS2_ff[7:0] == `CMD_CFG_SETUP) begin
            nxt_pend = 1'b1;
         end else if (dqS2_ff[7:0] == `CMD_READ_IDENT) begin
            nxt_space = flash_rcr_pkg::SPACE_IDENT;
         end else if (dqS2_ff[7:0] == `CMD_READ_ARRAY) begin
            nxt_space = flash_rcr_pkg::SPACE_ARRAY;
         end else begin
            nxt_pend = 1'b0;
         end
      end else begin
         nxt_pend = pend_ff;
      end
      nxt_tog = tog_ff ^ ((nxt_cfg != cfg_ff) || (nxt_space != space_ff));
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff   <= `RCR_RESET;
         space_ff <= flash_rcr_pkg::SPACE_ARRAY;
         pend_ff  <= 1'b0;
         tog_ff   <= 1'b0;
      end else begin
         cfg_ff   <= nxt_cfg;
         space_ff <= nxt_space;
         pend_ff  <= nxt_pend;
         tog_ff   <= nxt_tog;
      end
   end

   // ----------------------------------------
   // asynchronous page reads
   // ----------------------------------------
   logic [15:0] dqA_ff;
   logic [15:0] nxt_dqA;
   logic        dqOeA_ff;
   logic        nxt_dqOeA;

   always_comb begin
      nxt_dqOeA = cfg_ff.readModeSelect && !ctlS2_ff[2] && !ctlS2_ff[1];
      if (space_ff == flash_rcr_pkg::SPACE_IDENT) begin
         nxt_dqA = (addrS2_ff[7:0] == `IDENT_RCR_OFFSET) ? cfg_ff : 16'h0000;
      end else begin
         nxt_dqA = arrayRdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dqA_ff   <= 16'h0000;
         dqOeA_ff <= 1'b0;
      end else begin
         dqA_ff   <= nxt_dqA;
         dqOeA_ff <= nxt_dqOeA;
      end
   end

   // ----------------------------------------
   // link clock and configuration crossing
   // ----------------------------------------
   // edge select is a static clock inversion: change it only with the bus idle
   logic                     validClk;
   logic [2:0]               lTog_ff;
   flash_rcr_pkg::link_cfg_t lCfg_ff;

   assign validClk = linkClk ^ ~cfg_ff.clkRising;

   always_ff @(posedge validClk or negedge rst_n) begin
      if (!rst_n) begin
         lTog_ff <= 3'h0;
         lCfg_ff <= {`RCR_RESET, 1'b0};
      end else begin
         lTog_ff <= {lTog_ff[1:0], tog_ff};
         // word is stable for two edges before the toggle is seen
         // quiet pipe reloads too: two updates while the link clock rests
         // cancel in the toggle and would otherwise never cross
         if ((lTog_ff[2] ^ lTog_ff[1])
             || (lTog_ff[2] == lTog_ff[1] && lTog_ff[1] == lTog_ff[0])) begin
            lCfg_ff <= {cfg_ff, space_ff == flash_rcr_pkg::SPACE_IDENT};
         end
      end
   end

   // ----------------------------------------
   // synchronous burst engine
   // ----------------------------------------
   flash_rcr_pkg::burst_state_t state_ff;
   flash_rcr_pkg::burst_state_t nxt_state;
   flash_rcr_pkg::read_config_reg_t lc;
   logic [2:0]    latCnt_ff;
   logic [2:0]    nxt_latCnt;
   logic          hold_ff;
   logic          nxt_hold;
   logic [4:0]    wordCnt_ff;
   logic [4:0]    nxt_wordCnt;
   logic [AW-1:0] burstAddr_ff;
   logic [AW-1:0] nxt_burstAddr;
   logic [AW-1:0] wrapMask;
   logic [15:0]   dqS_ff;
   logic [15:0]   nxt_dqS;
   logic          dqOeS_ff;
   logic          nxt_dqOeS;
   logic          waitOut_ff;
   logic          nxt_waitOut;
   logic          waitOe_ff;
   logic          nxt_waitOe;
   logic [2:0]    lat;
   logic [4:0]    blen;
   logic          start;
   logic          step;
   logic          waitAct;

   always_comb begin
      lc  = lCfg_ff.cfg;
      lat = (lc.firstAccessLatency < `RCR_LAT_MIN) ? `RCR_LAT_MIN
            : lc.firstAccessLatency;
      unique case (lc.burstLength)
         `RCR_BL_4:  blen = 5'h04;
         `RCR_BL_8:  blen = 5'h08;
         `RCR_BL_16: blen = 5'h10;
         default:    blen = 5'h00;
      endcase
      wrapMask      = AW'(blen - 5'h01);
      start         = !ceN && !addressValidN && !lc.readModeSelect;
      step          = 1'b0;
      nxt_state     = state_ff;
      nxt_latCnt    = latCnt_ff;
      nxt_hold      = hold_ff;
      nxt_wordCnt   = wordCnt_ff;
      nxt_burstAddr = burstAddr_ff;
      if (ceN) begin
         nxt_state = flash_rcr_pkg::BUS_IDLE;
      end else if (start) begin
         // latency counts from the last valid edge with address valid
         nxt_state     = flash_rcr_pkg::BUS_LATENCY;
         nxt_latCnt    = 3'h0;
         nxt_burstAddr = addr;
         nxt_wordCnt   = 5'h00;
      end else begin
         unique case (state_ff)
            flash_rcr_pkg::BUS_IDLE: begin
               nxt_state = flash_rcr_pkg::BUS_IDLE;
            end
            flash_rcr_pkg::BUS_LATENCY: begin
               nxt_latCnt = latCnt_ff + 3'h1;
               if (nxt_latCnt == lat) begin
                  nxt_state = flash_rcr_pkg::BUS_DATA;
                  step      = 1'b1;
               end
            end
            flash_rcr_pkg::BUS_DATA: begin
               if (lc.dataHoldLen && !hold_ff) begin
                  nxt_hold = 1'b1;
               end else if (blen == 5'h00 || wordCnt_ff != blen) begin
                  step = 1'b1;
               end else begin
                  // fixed length done: last word stays on the bus
                  nxt_hold = hold_ff;
               end
            end
         endcase
      end
      nxt_dqS = dqS_ff;
      if (step) begin
         nxt_hold    = 1'b0;
         nxt_wordCnt = nxt_wordCnt + 5'h01;
         if (lCfg_ff.identMode) begin
            // non-array word is repeated, address held
            nxt_dqS = (nxt_burstAddr[7:0] == `IDENT_RCR_OFFSET) ? lc : 16'h0000;
         end else begin
            nxt_dqS = arrayRdata;
            if (lc.burstWrapCtl || blen == 5'h00) begin
               nxt_burstAddr = nxt_burstAddr + AW'(1);
            end else begin
               nxt_burstAddr = (nxt_burstAddr & ~wrapMask)
                               | ((nxt_burstAddr + AW'(1)) & wrapMask);
            end
         end
      end
      // early release one data cycle ahead of the first word
      waitAct = (nxt_state == flash_rcr_pkg::BUS_LATENCY)
                && !(lc.waitDelaySel && ({1'b0, nxt_latCnt}
                + (lc.dataHoldLen ? 4'h2 : 4'h1)) >= {1'b0, lat});
      nxt_dqOeS   = !ceN && !oeN && nxt_state == flash_rcr_pkg::BUS_DATA;
      nxt_waitOut = waitAct ? lc.waitHigh : !lc.waitHigh;
      nxt_waitOe  = !ceN && !oeN;
   end

   // all wait changes land on valid edges only
   always_ff @(posedge validClk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff     <= flash_rcr_pkg::BUS_IDLE;
         latCnt_ff    <= 3'h0;
         hold_ff      <= 1'b0;
         wordCnt_ff   <= 5'h00;
         burstAddr_ff <= '0;
         dqS_ff       <= 16'h0000;
         dqOeS_ff     <= 1'b0;
         waitOut_ff   <= 1'b0;
         waitOe_ff    <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         latCnt_ff    <= nxt_latCnt;
         hold_ff      <= nxt_hold;
         wordCnt_ff   <= nxt_wordCnt;
         burstAddr_ff <= nxt_burstAddr;
         dqS_ff       <= nxt_dqS;
         dqOeS_ff     <= nxt_dqOeS;
         waitOut_ff   <= nxt_waitOut;
         waitOe_ff    <= nxt_waitOe;
      end
   end

   // ----------------------------------------
   // pin outputs
   // ----------------------------------------
   // read mode is static while the bus is used, so the select never glitches
   assign dqOut      = cfg_ff.readModeSelect ? dqA_ff : dqS_ff;
   assign dqOe       = cfg_ff.readModeSelect ? dqOeA_ff : dqOeS_ff;
   assign arrayRaddr = cfg_ff.readModeSelect ? addrS2_ff : burstAddr_ff;
   assign waitOut    = waitOut_ff;
   assign waitOe     = waitOe_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [3:0] edgeCnt_ff;

   always_ff @(posedge validClk or negedge rst_n) begin
      if (!rst_n) begin
         edgeCnt_ff <= 4'h0;
      end else if (start) begin
         edgeCnt_ff <= 4'h0;
      end else if (edgeCnt_ff != 4'hF) begin
         edgeCnt_ff <= edgeCnt_ff + 4'h1;
      end
   end

   a_cfg_reset_value: assert property (@(posedge ref_clk)
      !rst_n |=> cfg_ff == `RCR_RESET)
      else $error("config not at default after reset");
   a_cfg_only_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !cfgWrite |=> $stable(cfg_ff))
      else $error("config changed without command");
   a_ident_offset: assert property (@(posedge ref_clk) disable iff (!rst_n)
      space_ff == flash_rcr_pkg::SPACE_IDENT && addrS2_ff[7:0] == `IDENT_RCR_OFFSET
      && !cfgWrite |=> dqA_ff == cfg_ff)
      else $error("identifier offset does not return config");
   a_first_latency: assert property (@(posedge validClk) disable iff (!rst_n)
      $rose(state_ff == flash_rcr_pkg::BUS_DATA) |-> edgeCnt_ff == {1'b0, lat})
      else $error("first data not at latency count");
   a_wait_hiz: assert property (@(posedge validClk) disable iff (!rst_n)
      ceN || oeN |=> !waitOe_ff)
      else $error("wait driven with bus inactive");
   a_wait_async: assert property (@(posedge validClk) disable iff (!rst_n)
      lc.readModeSelect && $stable(lCfg_ff) |-> waitOut_ff == !lc.waitHigh)
      else $error("wait asserted in async mode");
   a_wait_data: assert property (@(posedge validClk) disable iff (!rst_n)
      dqOeS_ff |-> waitOut_ff == !lc.waitHigh)
      else $error("wait asserted during valid data");
   a_hold_two: assert property (@(posedge validClk) disable iff (!rst_n)
      $rose(state_ff == flash_rcr_pkg::BUS_DATA) && lc.dataHoldLen && !ceN
      ##1 !ceN && !start |-> $stable(wordCnt_ff))
      else $error("word changed inside two-clock hold");
   a_ident_repeat: assert property (@(posedge validClk) disable iff (!rst_n)
      lCfg_ff.identMode && state_ff == flash_rcr_pkg::BUS_DATA && !start
      && !ceN |=> $stable(dqS_ff))
      else $error("non-array word not repeated");

   c_sync_burst: cover property (@(posedge validClk) disable iff (!rst_n)
      $rose(state_ff == flash_rcr_pkg::BUS_DATA) && !lCfg_ff.identMode);
   c_ident_burst: cover property (@(posedge validClk) disable iff (!rst_n)
      $rose(state_ff == flash_rcr_pkg::BUS_DATA) && lCfg_ff.identMode);
   c_async_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(dqOeA_ff));
   c_cfg_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
      cfgWrite);
endmodule
`default_nettype wire

// file: bench/flash_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// host bus side of the flash
// ------------------------------
module flash_host_model (
   input  wire logic        ref_clk,
   output var  logic        linkClk,
   output var  logic        ceN,
   output var  logic        oeN,
   output var  logic        weN,
   output var  logic        addressValidN,
   output var  logic [15:0] addr,
   output var  logic [15:0] dqIn
);
   logic linkRun;
   logic rise;

   initial begin
      linkClk       = 1'b0;
      ceN           = 1'b1;
      oeN           = 1'b1;
      weN           = 1'b1;
      addressValidN = 1'b1;
      addr          = 16'h0000;
      dqIn          = 16'h0000;
      linkRun       = 1'b1;
      rise          = 1'b1;
   end

   // odd start offset keeps the link unrelated in phase to ref_clk
   initial begin
      #3;
      forever begin
         #16;
         if (linkRun) linkClk = ~linkClk;
      end
   end

   // clock rests low between frames
   task automatic linkStop();
      @(negedge linkClk);
      linkRun = 1'b0;
   endtask

   task automatic vedge();
      do @(linkClk); while (linkClk !== rise);
   endtask

   task automatic writeCmd(input logic [7:0] cmd, input logic [15:0] a);
      @(negedge ref_clk);
      ceN  = 1'b0;
      weN  = 1'b0;
      addr = a;
      dqIn = {8'h00, cmd};
      repeat (4) @(negedge ref_clk);
      weN = 1'b1;
      // data kept well past the synced edge the device takes it on
      repeat (6) @(negedge ref_clk);
      ceN  = 1'b1;
      addr = ~a;
      dqIn = ~dqIn;
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic asyncOn(input logic [15:0] a);
      linkRun = 1'b1;
      @(negedge ref_clk);
      ceN  = 1'b0;
      oeN  = 1'b0;
      addr = a;
   endtask

   task automatic startBurst(input logic [15:0] a);
      linkRun = 1'b1;
      // idle edges let the new setup cross into the link domain
      repeat (4) @(posedge linkClk);
      vedge();
      @(negedge ref_clk);
      ceN           = 1'b0;
      oeN           = 1'b0;
      addressValidN = 1'b0;
      addr          = a;
      vedge();
      @(negedge ref_clk);
      addressValidN = 1'b1;
      addr          = ~a;
   endtask

   task automatic busOff();
      @(negedge ref_clk);
      ceN  = 1'b1;
      oeN  = 1'b1;
      addr = ~addr;
      repeat (3) @(posedge linkClk);
      linkStop();
   endtask
endmodule
`default_nettype wire

// file: bench/test_flash_read_config_burst.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// config and burst tests
// ------------------------------
module test_flash_read_config_burst;
   logic        ref_clk;
   logic        rst_n;
   logic        linkClk;
   logic        ceN;
   logic        oeN;
   logic        weN;
   logic        addressValidN;
   logic        dqOe;
   logic        waitOut;
   logic        waitOe;
   logic [15:0] addr;
   logic [15:0] dqIn;
   logic [15:0] arrayRdata;
   logic [15:0] dqOut;
   logic [15:0] arrayRaddr;
   int          err_count;
   int          n_compared;
   // codes legal for a 31 MHz link
   logic [15:0] cfgTab   [4] = '{16'h1CC1, 16'h23CA, 16'h1D83, 16'h1CC1};
   logic [15:0] startTab [4] = '{16'h0002, 16'h0006, 16'h000E, 16'h0005};

   // array stand-in: each word is its inverted address
   assign arrayRdata = ~arrayRaddr;

   flash_host_model host_u (
      .ref_clk       (ref_clk),
      .linkClk       (linkClk),
      .ceN           (ceN),
      .oeN           (oeN),
      .weN           (weN),
      .addressValidN (addressValidN),
      .addr          (addr),
      .dqIn          (dqIn)
   );

   flash_read_config_burst #(.AW(16)) dut_u (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .linkClk       (linkClk),
      .ceN           (ceN),
      .oeN           (oeN),
      .weN           (weN),
      .addressValidN (addressValidN),
      .addr          (addr),
      .dqIn          (dqIn),
      .arrayRdata    (arrayRdata),
      .dqOut         (dqOut),
      .dqOe          (dqOe),
      .waitOut       (waitOut),
      .waitOe        (waitOe),
      .arrayRaddr    (arrayRaddr)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (err_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic idleChk();
      chk({14'h0000, dqOe, waitOe}, 16'h0000);
   endtask

   task automatic asyncRead(input logic [15:0] a, input logic [15:0] d, input logic w);
      host_u.asyncOn(a);
      repeat (12) @(negedge ref_clk);
      chk(dqOut, d);
      chk({13'h0000, dqOe, waitOe, waitOut}, {13'h0000, 1'b1, 1'b1, w});
      host_u.busOff();
      repeat (4) @(negedge ref_clk);
      idleChk();
   endtask

   task automatic burst(input logic [15:0] c, input logic [15:0] s, input logic ident);
      int          lat;
      int          hold;
      int          len;
      int          rel;
      int          j;
      logic [15:0] a;
      lat  = (c[13:11] < 3'h2) ? 2 : int'(c[13:11]);
      hold = c[9] ? 2 : 1;
      len  = (c[2:0] == 3'h1) ? 4 : (c[2:0] == 3'h2) ? 8 : (c[2:0] == 3'h3) ? 16 : 0;
      rel  = c[8] ? lat - hold : lat;
      host_u.rise = c[6];
      host_u.startBurst(s);
      for (int k = 1; k < lat + 4 * hold; k++) begin
         host_u.vedge();
         #1;
         if (k < lat) begin
            chk({14'h0000, dqOe, waitOe}, 16'h0001);
            chk({15'h0000, waitOut}, {15'h0000, (k < rel) ? c[10] : ~c[10]});
         end else begin
            j = (k - lat) / hold;
            if (len != 0 && !c[3])
               a = 16'((int'(s) & ~(len - 1)) | ((int'(s) + j) & (len - 1)));
            else
               a = 16'(int'(s) + j);
            chk(dqOut, ident ? c : ~a);
            chk({14'h0000, dqOe, waitOut}, {14'h0000, 1'b1, ~c[10]});
         end
      end
      host_u.busOff();
      idleChk();
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // whole run needs about 7 us
   initial begin
      #400000;
      err_count++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      host_u.linkStop();
      repeat (4) @(negedge ref_clk);
      idleChk();
      host_u.writeCmd(8'h90, 16'h0000);
      asyncRead(16'h0005, 16'hBFCF, 1'b0);
      asyncRead(16'h0003, 16'h0000, 1'b0);
      // confirm with no setup before it must be dropped
      host_u.writeCmd(8'h03, 16'h1234);
      asyncRead(16'h0005, 16'hBFCF, 1'b0);
      // reserved bits set on purpose
      host_u.writeCmd(8'h60, 16'h0000);
      host_u.writeCmd(8'h03, 16'hC030);
      asyncRead(16'h0005, 16'h8080, 1'b1);
      host_u.writeCmd(8'hFF, 16'h0000);
      asyncRead(16'h0123, 16'hFEDC, 1'b1);
      for (int i = 0; i < 4; i++) begin
         host_u.writeCmd(8'h60, 16'h0000);
         host_u.writeCmd(8'h03, cfgTab[i]);
         host_u.writeCmd((i == 3) ? 8'h90 : 8'hFF, 16'h0000);
         burst(cfgTab[i], startTab[i], i == 3);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
